// ---- design/temp_conv_ctrl.sv ----
`timescale 1ns/1ps
// Contract
// RULE1 - Auto-convert repeatedly while standby pin high and standby bit clear.
// RULE2 - One-shot command starts a single conversion outside the schedule.
// RULE3 - Automatic conversion interval set by the conversion rate register.
// RULE4 - Steer current sources through local then remote sensor within 60 ms.
// RULE5 - Store each result as 8-bit two's complement temperature.
// RULE6 - Compare each stored result with that channel's high and low limits.
// RULE7 - Record comparison outcomes as flag bits in status register.
// RULE8 - Out-of-limit result pulls the alert output low.
// RULE9 - Both channels each conversion; both updated only on success.
// RULE10 - Reported temperature is the average of ten converter results.
// RULE11 - Decode each address pin as low, high or unconnected.
// RULE12 - Sample and latch address pins at the start of every conversion.
// RULE13 - Bias address pins with a current and compare against thresholds.
// RULE14 - No clock-low timeout on the serial interface.
// RULE15 - Host keeps serial clock at or below 100 kHz.
// RULE16 - Standby pin during conversion abandons it, temperatures unchanged.
// RULE17 - Standby pin ignores one-shot; software standby still honours it.
// RULE18 - Configuration bit 7 set masks the alert output.
// RULE19 - One-shot during a conversion waits until that conversion ends.
module temp_conv_ctrl #(
	parameter int MS_CYCLES = temp_conv_pkg::MS_CYCLES_DEF
) (
	input  wire logic        CLOCK,
	input  wire logic        SYS_RST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        HW_STANDBY_INPUT_N,
	input  wire logic        SMBUS_CLK,
	input  wire logic        SERIAL_DATA_PIN_I,
	input  wire logic        ADDR_SELECT_PIN_0_ABOVE,
	input  wire logic        ADDR_SELECT_PIN_0_BELOW,
	input  wire logic        ADDR_SELECT_PIN_1_ABOVE,
	input  wire logic        ADDR_SELECT_PIN_1_BELOW,
	output logic             ADDR_BIAS_EN,
	output logic             CUR_SRC_EN,
	output logic             MUX_REMOTE,
	output logic             ADC_START,
	input  wire logic        ADC_DONE,
	input  wire logic [7:0]  ADC_DATA,
	output logic             ALERT_O,
	output logic             ALERT_OE,
	output logic             IRQ
);
	import temp_conv_pkg::*;

	// ----------------------------------------------------------------
	// Types and helpers
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		C_IDLE,
		C_SENSE,
		C_REQ,
		C_WAIT,
		C_FINISH
	} conv_st_t;

	typedef struct packed {
		conv_st_t                 st;
		logic                     hw_standby_input_s1;
		logic                     hw_standby_input_s2;
		logic [3:0]               cmp_s1;
		logic [3:0]               cmp_s2;
		logic [MS_CNT_W-1:0]      ms_cnt;
		logic [IVL_W-1:0]         ivl_ms;
		logic [WIN_W-1:0]         win_ms;
		logic [SENSE_W-1:0]       sense_cnt;
		logic [SAMP_W-1:0]        samp;
		logic signed [SUM_W-1:0]  sum_loc;
		logic signed [SUM_W-1:0]  sum_rem;
		logic [7:0]               temp_loc;
		logic [7:0]               temp_rem;
		logic [7:0]               cfg;
		logic [7:0]               rate;
		logic [7:0]               loc_hi;
		logic [7:0]               loc_lo;
		logic [7:0]               rem_hi;
		logic [7:0]               rem_lo;
		logic [1:0]               lvl0;
		logic [1:0]               lvl1;
		logic [ST_W-1:0]          status;
		logic [ST_W-1:0]          irq_en;
		logic                     os_pend;
		logic                     adc_start;
		logic                     cur_en;
		logic                     bias_en;
		logic                     mux_rem;
		logic                     alert_oe;
		logic                     irq;
		logic                     pready;
		logic                     pslverr;
		logic [31:0]              prdata;
	} ctrl_t;

	function automatic logic [1:0] pin_level(logic above, logic below);
		if (below)
			return LVL_GND;
		else if (above)
			return LVL_VDD;
		else
			return LVL_NC;
	endfunction

	function automatic logic [7:0] avg_ten(logic signed [SUM_W-1:0] sum);
		int s;
		s = int'(sum);
		if (s >= 0)
			s = (s + SAMPLES_PER_CH / 2) / SAMPLES_PER_CH;
		else
			s = -((SAMPLES_PER_CH / 2 - s) / SAMPLES_PER_CH);
		return 8'(s);
	endfunction

	function automatic logic [IVL_W-1:0] interval_ms(logic [7:0] code);
		int c;
		c = (int'(code) > RATE_CODE_MAX) ? RATE_CODE_MAX : int'(code);
		return IVL_W'(RATE_BASE_MS >> c);
	endfunction

	function automatic logic [1:0] limit_flags(logic [7:0] t,
	                                           logic [7:0] hi,
	                                           logic [7:0] lo);
		return {$signed(t) < $signed(lo), $signed(t) > $signed(hi)};
	endfunction

	ctrl_t q;
	ctrl_t d;

	link_watch_if lw ();

	link_watch u_link_watch (
		.clk      (CLOCK),
		.rst      (SYS_RST),
		.sclk_raw (SMBUS_CLK),
		.sda_raw  (SERIAL_DATA_PIN_I),
		.lw       (lw)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic                    hw_hw_standby_input;
	logic                    run;
	logic                    tick;
	logic                    acc;
	logic                    wr;
	logic                    set_os;
	logic                    take_os;
	logic [ST_W-1:0]         clr_st;
	logic [ST_W-1:0]         set_st;
	logic [7:0]              t_loc;
	logic [7:0]              t_rem;
	logic [1:0]              fl_loc;
	logic [1:0]              fl_rem;
	logic signed [SUM_W-1:0] sample;

	always_comb begin
		d           = q;
		d.adc_start = 1'b0;
		d.pready    = 1'b0;
		d.pslverr   = 1'b0;
		d.hw_standby_input_s1   = HW_STANDBY_INPUT_N;
		d.hw_standby_input_s2   = q.hw_standby_input_s1;
		d.cmp_s1    = {ADDR_SELECT_PIN_1_ABOVE, ADDR_SELECT_PIN_1_BELOW,
		               ADDR_SELECT_PIN_0_ABOVE, ADDR_SELECT_PIN_0_BELOW};
		d.cmp_s2    = q.cmp_s1;
		hw_hw_standby_input     = !q.hw_standby_input_s2;
		run         = !hw_hw_standby_input && !q.cfg[CFG_HW_STANDBY_INPUT_BIT]; // [RULE1]
		tick        = (q.ms_cnt == MS_CNT_W'(MS_CYCLES - 1));
		d.ms_cnt    = tick ? '0 : q.ms_cnt + 1'b1;
		set_os      = 1'b0;
		take_os     = 1'b0;
		clr_st      = '0;
		set_st      = '0;
		sample      = {{(SUM_W - 8){ADC_DATA[7]}}, ADC_DATA};
		t_loc       = avg_ten(q.sum_loc); // [RULE10]
		t_rem       = avg_ten(q.sum_rem); // [RULE10]
		fl_loc      = limit_flags(t_loc, q.loc_hi, q.loc_lo);
		fl_rem      = limit_flags(t_rem, q.rem_hi, q.rem_lo);

		// APB slave: answer one cycle into the access phase
		acc = PSEL && PENABLE && !q.pready;
		wr  = acc && PWRITE;
		if (acc) begin
			d.pready = 1'b1;
			d.prdata = '0;
			case (PADDR)
			OFS_TEMP_LOCAL:  d.prdata = 32'(q.temp_loc);
			OFS_TEMP_REMOTE: d.prdata = 32'(q.temp_rem);
			OFS_STATUS:      d.prdata = 32'(q.status);
			OFS_CONFIG: begin
				d.prdata = 32'(q.cfg);
				if (wr)
					d.cfg = PWDATA[7:0] & CONFIG_USED;
			end
			OFS_CONV_RATE: begin
				d.prdata = 32'(q.rate);
				if (wr)
					d.rate = PWDATA[7:0];
			end
			OFS_LOC_HI_LIM: begin
				d.prdata = 32'(q.loc_hi);
				if (wr)
					d.loc_hi = PWDATA[7:0];
			end
			OFS_LOC_LO_LIM: begin
				d.prdata = 32'(q.loc_lo);
				if (wr)
					d.loc_lo = PWDATA[7:0];
			end
			OFS_REM_HI_LIM: begin
				d.prdata = 32'(q.rem_hi);
				if (wr)
					d.rem_hi = PWDATA[7:0];
			end
			OFS_REM_LO_LIM: begin
				d.prdata = 32'(q.rem_lo);
				if (wr)
					d.rem_lo = PWDATA[7:0];
			end
			OFS_ONE_SHOT:   set_os = wr;
			OFS_STATUS_CLR: clr_st = wr ? PWDATA[ST_W-1:0] : '0;
			OFS_IRQ_ENABLE: begin
				d.prdata = 32'(q.irq_en);
				if (wr)
					d.irq_en = PWDATA[ST_W-1:0];
			end
			OFS_INFO: d.prdata = {16'h0000, lw.start_count, 2'h0, lw.busy,
			                      q.st != C_IDLE, q.lvl1, q.lvl0};
			default:  d.pslverr = 1'b1;
			endcase
		end

		// ------------------------------------------------------------
		// Conversion sequencer
		// ------------------------------------------------------------
		if (q.st != C_IDLE && tick)
			d.win_ms = q.win_ms + 1'b1;
		// Interval runs start to start, also through a conversion
		if (run && tick && q.ivl_ms != '0)
			d.ivl_ms = q.ivl_ms - 1'b1;               // [RULE3]
		case (q.st)
		C_IDLE: begin
			if (!hw_hw_standby_input && (q.os_pend || (run && q.ivl_ms == '0))) begin
				take_os     = 1'b1;                   // [RULE2] [RULE17]
				d.ivl_ms    = interval_ms(q.rate);    // [RULE3]
				d.win_ms    = '0;
				d.sense_cnt = '0;
				d.bias_en   = 1'b1;                   // [RULE13]
				d.st        = C_SENSE;
			end
		end
		C_SENSE: begin
			d.sense_cnt = q.sense_cnt + 1'b1;
			if (q.sense_cnt == SENSE_W'(ADDR_SENSE_CYCLES - 1)) begin
				d.lvl0    = pin_level(q.cmp_s2[1], q.cmp_s2[0]); // [RULE11] [RULE12]
				d.lvl1    = pin_level(q.cmp_s2[3], q.cmp_s2[2]); // [RULE11] [RULE12]
				d.bias_en = 1'b0;
				d.cur_en  = 1'b1;                     // [RULE4]
				d.mux_rem = 1'b0;
				d.samp    = '0;
				d.sum_loc = '0;
				d.sum_rem = '0;
				d.st      = C_REQ;
			end
		end
		C_REQ: begin
			d.adc_start = 1'b1;
			d.st        = C_WAIT;
		end
		C_WAIT: begin
			if (ADC_DONE) begin
				if (q.mux_rem)
					d.sum_rem = q.sum_rem + sample;   // [RULE10]
				else
					d.sum_loc = q.sum_loc + sample;   // [RULE10]
				d.samp = q.samp + 1'b1;
				d.st   = C_REQ;
				if (q.samp == SAMP_W'(SAMPLES_PER_CH - 1)) begin
					d.samp = '0;
					if (q.mux_rem)
						d.st = C_FINISH;
					else
						d.mux_rem = 1'b1;             // [RULE4] [RULE9]
				end
			end
		end
		C_FINISH: begin
			d.temp_loc = t_loc;                       // [RULE5] [RULE9]
			d.temp_rem = t_rem;                       // [RULE5] [RULE9]
			set_st[ST_LOC_HI]    = fl_loc[0];         // [RULE6] [RULE7]
			set_st[ST_LOC_LO]    = fl_loc[1];         // [RULE6] [RULE7]
			set_st[ST_REM_HI]    = fl_rem[0];         // [RULE6] [RULE7]
			set_st[ST_REM_LO]    = fl_rem[1];         // [RULE6] [RULE7]
			set_st[ST_CONV_DONE] = 1'b1;
			d.cur_en  = 1'b0;
			d.mux_rem = 1'b0;
			d.st      = C_IDLE;
		end
		default: d.st = C_IDLE;
		endcase

		// Window overrun or hardware standby drops the conversion
		if (q.st != C_IDLE && q.st != C_FINISH) begin
			if (hw_hw_standby_input ||
			    (tick && q.win_ms == WIN_W'(MEAS_WINDOW_MS - 1))) begin
				d.st        = C_IDLE;                 // [RULE16] [RULE4]
				d.cur_en    = 1'b0;
				d.bias_en   = 1'b0;
				d.mux_rem   = 1'b0;
				d.adc_start = 1'b0;
				set_st[ST_CONV_FAIL] = !hw_hw_standby_input;
			end
		end

		// Pending one-shot: held through a running conversion
		d.os_pend = (q.os_pend && !take_os) || set_os;  // [RULE19]
		if (hw_hw_standby_input)
			d.os_pend = 1'b0;                         // [RULE17]

		// Sticky status: a new event beats a same-cycle clear
		d.status   = (q.status & ~clr_st) | set_st;   // [RULE7]
		d.alert_oe = |(d.status & ST_LIMIT_MASK) &&
		             !q.cfg[CFG_MASK_BIT];            // [RULE8] [RULE18]
		d.irq      = |(d.status & q.irq_en);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			q          <= '0;
			q.st       <= C_IDLE;
			q.hw_standby_input_s1  <= 1'b1;
			q.hw_standby_input_s2  <= 1'b1;
			q.temp_loc <= TEMP_RST;
			q.temp_rem <= TEMP_RST;
			q.cfg      <= CONFIG_RST;
			q.rate     <= CONV_RATE_RST;
			q.loc_hi   <= HI_LIM_RST;
			q.loc_lo   <= LO_LIM_RST;
			q.rem_hi   <= HI_LIM_RST;
			q.rem_lo   <= LO_LIM_RST;
			q.lvl0     <= LVL_GND;
			q.lvl1     <= LVL_GND;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign PRDATA       = q.prdata;
	assign PREADY       = q.pready;
	assign PSLVERR      = q.pslverr;
	assign ADDR_BIAS_EN = q.bias_en;
	assign CUR_SRC_EN   = q.cur_en;
	assign MUX_REMOTE   = q.mux_rem;
	assign ADC_START    = q.adc_start;
	assign ALERT_O      = 1'b0;
	assign ALERT_OE     = q.alert_oe;
	assign IRQ          = q.irq;
endmodule

// ---- design/temp_conv_pkg.sv ----
package temp_conv_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ            = 40_000_000;
	localparam int MS_CYCLES_DEF     = CLK_HZ / 1000;
	localparam int MEAS_WINDOW_MS    = 60;
	localparam int ADDR_SENSE_US     = 10;
	localparam int ADDR_SENSE_CYCLES =
		(ADDR_SENSE_US * (CLK_HZ / 1000) + 999) / 1000;
	localparam int RATE_BASE_MS      = 16000;
	localparam int RATE_CODE_MAX     = 7;
	localparam int SAMPLES_PER_CH    = 10;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int MS_CNT_W = 16;
	localparam int IVL_W    = 14;
	localparam int WIN_W    = 7;
	localparam int SENSE_W  = 9;
	localparam int SAMP_W   = 4;
	localparam int SUM_W    = 12;
	localparam int ST_W     = 6;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_TEMP_LOCAL  = 8'h00;
	localparam logic [7:0] OFS_TEMP_REMOTE = 8'h04;
	localparam logic [7:0] OFS_STATUS      = 8'h08;
	localparam logic [7:0] OFS_CONFIG      = 8'h0c;
	localparam logic [7:0] OFS_CONV_RATE   = 8'h10;
	localparam logic [7:0] OFS_LOC_HI_LIM  = 8'h14;
	localparam logic [7:0] OFS_LOC_LO_LIM  = 8'h18;
	localparam logic [7:0] OFS_REM_HI_LIM  = 8'h1c;
	localparam logic [7:0] OFS_REM_LO_LIM  = 8'h20;
	localparam logic [7:0] OFS_ONE_SHOT    = 8'h24;
	localparam logic [7:0] OFS_STATUS_CLR  = 8'h28;
	localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h2c;
	localparam logic [7:0] OFS_INFO        = 8'h30;

	// ----------------------------------------------------------------
	// Reset values and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] TEMP_RST     = 8'h00;
	localparam logic [7:0] CONFIG_RST   = 8'h00;
	localparam logic [7:0] CONV_RATE_RST = 8'h02;
	localparam logic [7:0] HI_LIM_RST   = 8'h7f;
	localparam logic [7:0] LO_LIM_RST   = 8'hc9;
	localparam logic [7:0] CONFIG_USED  = 8'hc0;
	localparam int         CFG_MASK_BIT = 7;
	localparam int         CFG_HW_STANDBY_INPUT_BIT = 6;

	localparam int ST_LOC_HI    = 0;
	localparam int ST_LOC_LO    = 1;
	localparam int ST_REM_HI    = 2;
	localparam int ST_REM_LO    = 3;
	localparam int ST_CONV_DONE = 4;
	localparam int ST_CONV_FAIL = 5;
	localparam logic [ST_W-1:0] ST_LIMIT_MASK = 6'h0f;

	// Address pin levels
	localparam logic [1:0] LVL_GND = 2'h0;
	localparam logic [1:0] LVL_NC  = 2'h1;
	localparam logic [1:0] LVL_VDD = 2'h2;

endpackage

// ---- design/link_watch_if.sv ----
`timescale 1ns/1ps
interface link_watch_if;
	logic       busy;
	logic [7:0] start_count;
	modport watcher (output busy, output start_count);
	modport user    (input busy, input start_count);
endinterface

// ---- design/link_watch.sv ----
`timescale 1ns/1ps
module link_watch (
	input  wire logic      clk,
	input  wire logic      rst,
	input  wire logic      sclk_raw,
	input  wire logic      sda_raw,
	link_watch_if.watcher  lw
);
	import temp_conv_pkg::*;

	typedef struct packed {
		logic       scl_s1;
		logic       scl_s2;
		logic       sda_s1;
		logic       sda_s2;
		logic       sda_s3;
		logic       busy;
		logic [7:0] starts;
	} watch_t;

	watch_t q;
	watch_t d;

	// ----------------------------------------------------------------
	// Start and stop detection
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		d.scl_s1 = sclk_raw;
		d.scl_s2 = q.scl_s1;
		d.sda_s1 = sda_raw;
		d.sda_s2 = q.sda_s1;
		d.sda_s3 = q.sda_s2;
		// Busy ends only with a stop, never by a clock-low timer [RULE14]
		if (q.scl_s2 && q.sda_s3 && !q.sda_s2) begin
			d.busy   = 1'b1;
			d.starts = q.starts + 8'h01;
		end else if (q.scl_s2 && !q.sda_s3 && q.sda_s2) begin
			d.busy = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q        <= '0;
			q.scl_s1 <= 1'b1;
			q.scl_s2 <= 1'b1;
			q.sda_s1 <= 1'b1;
			q.sda_s2 <= 1'b1;
			q.sda_s3 <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign lw.busy        = q.busy;
	assign lw.start_count = q.starts;
endmodule

// ---- dv/afe_model.sv ----
`timescale 1ns/1ps
module afe_model (
	input  wire logic       clk,
	input  wire logic       cur_en,
	input  wire logic       remote,
	input  wire logic       start,
	input  wire logic       bias,
	input  wire logic [7:0] loc_base,
	input  wire logic [7:0] rem_base,
	input  wire logic [1:0] lvl0,
	input  wire logic [1:0] lvl1,
	input  wire logic [2:0] dly,
	output logic            done,
	output logic [7:0]      data,
	output logic [3:0]      cmp
);
	import temp_conv_pkg::*;
	int   n = 0;
	int   w = 0;
	logic tgl = 1'b0;
	initial done = 1'b0;
	initial data = 8'h00;
	// ----------------------------------------------------------------
	// Converter: sample spread around the base, data garbage between
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		tgl <= !tgl;
		done <= 1'b0;
		data <= ~data;
		if (!cur_en)
			n <= 0;
		if (start)
			w <= int'(dly);
		else if (w > 1)
			w <= w - 1;
		else if (w == 1) begin
			w <= 0;
			done <= 1'b1;
			data <= (remote ? rem_base : loc_base) + 8'((n % 10) % 3) - 8'h01;
			n <= n + 1;
		end
	end
	// Comparators only meaningful while bias current flows
	assign cmp = bias ? {lvl1 == LVL_VDD, lvl1 == LVL_GND,
		lvl0 == LVL_VDD, lvl0 == LVL_GND} : {4{tgl}};
endmodule

// ---- dv/temp_conv_checker.sv ----
`timescale 1ns/1ps
module temp_conv_checker #(
	parameter int MS_CYCLES = 40000
) (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic HW_STANDBY_INPUT_N,
	input wire logic ADDR_BIAS_EN,
	input wire logic CUR_SRC_EN,
	input wire logic MUX_REMOTE,
	input wire logic ADC_START,
	input wire logic ALERT_OE,
	input wire logic ALERT_O
);
	import temp_conv_pkg::*;
	int bias_n;
	int cur_n;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);
	always_ff @(posedge CLOCK) begin
		bias_n <= (SYS_RST || !ADDR_BIAS_EN) ? 0 : bias_n + 1;
		cur_n <= (SYS_RST || !CUR_SRC_EN) ? 0 : cur_n + 1;
	end
	sequence sense_done;
		$fell(ADDR_BIAS_EN) ##0 HW_STANDBY_INPUT_N;
	endsequence
	sequence meas_begin;
		CUR_SRC_EN && !MUX_REMOTE ##1 ADC_START;
	endsequence
	apb_answer_a: assert property (PSEL && $rose(PENABLE) |=> PREADY)
		else $error("no answer one cycle into access phase");
	err_ready_a: assert property (PSLVERR |-> PREADY)
		else $error("error flag without ready");
	alert_low_a: assert property ($rose(ALERT_OE) |->
		!ALERT_O && ($fell(CUR_SRC_EN) || $past(PREADY)))
		else $error("alert raised without a result or a write");
	sense_len_a: assert property (sense_done |->
		bias_n >= ADDR_SENSE_CYCLES - 1 && bias_n <= ADDR_SENSE_CYCLES + 1)
		else $error("address sense length wrong");
	sense_meas_a: assert property (sense_done |-> meas_begin)
		else $error("measurement did not follow address sense");
	meas_window_a: assert property (
		cur_n <= MEAS_WINDOW_MS * MS_CYCLES)
		else $error("measurement beyond window");
	start_meas_a: assert property (ADC_START |->
		CUR_SRC_EN && !ADDR_BIAS_EN ##1 !ADC_START)
		else $error("converter start outside measurement");
	hw_abort_a: assert property ($fell(HW_STANDBY_INPUT_N) |->
		##[1:5] !(CUR_SRC_EN || ADDR_BIAS_EN))
		else $error("standby did not stop conversion");
	hw_quiet_a: assert property ((!HW_STANDBY_INPUT_N)[*6] |->
		!ADDR_BIAS_EN && !CUR_SRC_EN)
		else $error("activity in hardware standby");
endmodule
bind temp_conv_ctrl temp_conv_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (
	.CLOCK(CLOCK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
	.PREADY(PREADY), .PSLVERR(PSLVERR),
	.HW_STANDBY_INPUT_N(HW_STANDBY_INPUT_N), .ADDR_BIAS_EN(ADDR_BIAS_EN),
	.CUR_SRC_EN(CUR_SRC_EN), .MUX_REMOTE(MUX_REMOTE),
	.ADC_START(ADC_START), .ALERT_O(ALERT_O),
	.ALERT_OE(ALERT_OE)
);

// ---- dv/test_temp_conv_ctrl.sv ----
`timescale 1ns/1ps
module test_temp_conv_ctrl;
	import temp_conv_pkg::*;
	localparam int MS = 40;
	`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin \
		num_errors++; $display("MISMATCH t=%0t got=%h exp=%h", \
		$time, g, e); end end
	logic        CLOCK, SYS_RST, PSEL, PENABLE, PWRITE, err;
	logic        PREADY, PSLVERR, ADDR_BIAS_EN, CUR_SRC_EN, MUX_REMOTE;
	logic        ADC_START, ADC_DONE, ALERT_O, ALERT_OE, IRQ;
	logic        HW_STANDBY_INPUT_N, SCL, SDA;
	logic [7:0]  PADDR, ADC_DATA, loc_b, rem_b, e_loc, e_rem, e_st;
	logic [31:0] PWDATA, PRDATA, rd;
	logic [7:0]  lim [4];
	logic [7:0]  ie = 8'h00;
	logic [3:0]  cmp;
	logic [1:0]  lv0, lv1;
	logic [2:0]  dly;
	int          num_errors = 0;
	int          n_tests = 0;
	int          seed = 84;
	int          cyc = 0;
	int          n, k;
	logic [7:0]  rv [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h7f,
		8'hc9, 8'h7f, 8'hc9, 8'h00, 8'h00, 8'h00};
	temp_conv_ctrl #(.MS_CYCLES(MS)) u_dut (
		.CLOCK(CLOCK), .SYS_RST(SYS_RST), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .HW_STANDBY_INPUT_N(HW_STANDBY_INPUT_N),
		.SMBUS_CLK(SCL), .SERIAL_DATA_PIN_I(SDA),
		.ADDR_SELECT_PIN_0_ABOVE(cmp[1]),
		.ADDR_SELECT_PIN_0_BELOW(cmp[0]),
		.ADDR_SELECT_PIN_1_ABOVE(cmp[3]),
		.ADDR_SELECT_PIN_1_BELOW(cmp[2]),
		.ADDR_BIAS_EN(ADDR_BIAS_EN), .CUR_SRC_EN(CUR_SRC_EN),
		.MUX_REMOTE(MUX_REMOTE), .ADC_START(ADC_START),
		.ADC_DONE(ADC_DONE), .ADC_DATA(ADC_DATA), .ALERT_O(ALERT_O),
		.ALERT_OE(ALERT_OE), .IRQ(IRQ)
	);
	afe_model u_afe (
		.clk(CLOCK), .cur_en(CUR_SRC_EN), .remote(MUX_REMOTE),
		.start(ADC_START), .bias(ADDR_BIAS_EN), .loc_base(loc_b),
		.rem_base(rem_b), .lvl0(lv0), .lvl1(lv1), .dly(dly),
		.done(ADC_DONE), .data(ADC_DATA), .cmp(cmp)
	);
	initial begin
		CLOCK = 1'b0;
		forever #12.5 CLOCK = ~CLOCK;
	end
	always @(posedge CLOCK) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			num_errors++;
			wrap_up();
		end
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int t;
		t = 0;
		@(posedge CLOCK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		do @(posedge CLOCK); while (PREADY !== 1'b1 && ++t < 20);
		if (PREADY !== 1'b1)
			num_errors++;
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, {24'h0, e})
	endtask
	task automatic wt(input logic b, input logic v, output int c);
		c = 0;
		while ((b ? ADDR_BIAS_EN : CUR_SRC_EN) !== v && c < 12000) begin
			@(posedge CLOCK);
			c++;
		end
		if (c >= 12000)
			num_errors++;
	endtask
	function automatic logic [7:0] avg(input logic [7:0] b);
		int s;
		s = 0;
		for (int i = 0; i < 10; i++)
			s += $signed(b) + (i % 3) - 1;
		avg = 8'((s >= 0) ? (s + 5) / 10 : -((5 - s) / 10));
	endfunction
	task automatic conv();
		wt(1'b0, 1'b1, n);
		wt(1'b0, 1'b0, n);
		e_loc = avg(loc_b);
		e_rem = avg(rem_b);
		e_st = {3'b000, 1'b1,
			$signed(e_rem) < $signed(lim[3]), $signed(e_rem) > $signed(lim[2]),
			$signed(e_loc) < $signed(lim[1]), $signed(e_loc) > $signed(lim[0])};
	endtask
	task automatic check(input logic m);
		repeat (2) @(posedge CLOCK);
		rchk(OFS_TEMP_LOCAL, e_loc);
		rchk(OFS_TEMP_REMOTE, e_rem);
		rchk(OFS_STATUS, e_st);
		`CHK(ALERT_OE, (|e_st[3:0]) & !m)
		`CHK(IRQ, |(e_st & ie))
		apb(1'b1, OFS_STATUS_CLR, 32'h3f);
		repeat (2) @(posedge CLOCK);
		`CHK({ALERT_OE, IRQ}, 2'b00)
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
		{HW_STANDBY_INPUT_N, SCL, SDA, SYS_RST} = 4'hf;
		lv0 = LVL_NC;
		lv1 = LVL_VDD;
		dly = 3'd2;
		loc_b = 8'd30;
		rem_b = 8'hf0;
		lim = '{8'h7f, 8'hc9, 8'h7f, 8'hc9};
		repeat (8) @(posedge CLOCK);
		SYS_RST <= 1'b0;
		foreach (rv[i]) rchk(8'(4 * i), rv[i]);
		apb(1'b0, 8'h40, 32'h0);
		`CHK({err, rd}, 33'h1_0000_0000)
		conv();
		check(1'b0);
		apb(1'b1, OFS_TEMP_LOCAL, 32'h55);
		rchk(OFS_TEMP_LOCAL, e_loc);
		apb(1'b0, OFS_INFO, 32'h0);
		`CHK(rd[3:0], {LVL_VDD, LVL_NC})
		apb(1'b1, OFS_CONV_RATE, 32'h7);
		ie = 8'h1f;
		apb(1'b1, OFS_IRQ_ENABLE, {24'h0, ie});
		for (int r = 0; r < 3; r++) begin
			loc_b <= 8'($random(seed) % 120);
			rem_b <= 8'($random(seed) % 120);
			dly <= 3'(1 + ($random(seed) & 3));
			foreach (lim[i]) begin
				lim[i] = 8'($random(seed));
				apb(1'b1, 8'h14 + 8'(4 * i), {24'h0, lim[i]});
			end
			apb(1'b1, OFS_CONFIG, {24'h0, r[0], 7'h40});
			apb(1'b1, OFS_ONE_SHOT, 32'h0);
			conv();
			check(r[0]);
		end
		apb(1'b1, OFS_ONE_SHOT, 32'h0);
		wt(1'b0, 1'b1, n);
		repeat (30) @(posedge CLOCK);
		HW_STANDBY_INPUT_N <= 1'b0;
		wt(1'b0, 1'b0, n);
		`CHK(n < 8, 1'b1)
		rchk(OFS_TEMP_LOCAL, e_loc);
		rchk(OFS_STATUS, 8'h00);
		apb(1'b1, OFS_ONE_SHOT, 32'h0);
		repeat (20) @(posedge CLOCK);
		HW_STANDBY_INPUT_N <= 1'b1;
		repeat (600) @(posedge CLOCK);
		apb(1'b0, OFS_INFO, 32'h0);
		`CHK(rd[4], 1'b0)
		apb(1'b1, OFS_ONE_SHOT, 32'h0);
		wt(1'b0, 1'b1, n);
		apb(1'b1, OFS_ONE_SHOT, 32'h0);
		conv();
		wt(1'b1, 1'b1, n);
		`CHK(n < 5, 1'b1)
		conv();
		check(1'b0);
		SDA <= 1'b0;
		repeat (9) begin
			#100 SCL <= 1'b0;
			#50 SDA <= 1'($random(seed));
			#50 SCL <= 1'b1;
		end
		#100 SCL <= 1'b0;
		repeat (1200) @(posedge CLOCK);
		apb(1'b0, OFS_INFO, 32'h0);
		`CHK(rd[5], 1'b1)
		SDA <= 1'b0;
		#100 SCL <= 1'b1;
		#100 SDA <= 1'b1;
		#200 apb(1'b0, OFS_INFO, 32'h0);
		`CHK({rd[15:8], rd[5]}, 9'h002)
		lv0 <= LVL_GND;
		lv1 <= LVL_NC;
		apb(1'b1, OFS_CONFIG, 32'h0);
		wt(1'b1, 1'b1, n);
		wt(1'b1, 1'b0, n);
		wt(1'b1, 1'b1, k);
		`CHK((n + k) >= (RATE_BASE_MS >> 7) * MS - MS, 1'b1)
		`CHK((n + k) <= (RATE_BASE_MS >> 7) * MS + MS, 1'b1)
		conv();
		check(1'b0);
		apb(1'b0, OFS_INFO, 32'h0);
		`CHK(rd[3:0], {LVL_NC, LVL_GND})
		wrap_up();
	end
endmodule
